// ### host_char_source.sv
// host model driving the character bus and input clocks
`timescale 1ns/1ns
module host_char_source
    import quad_tx_pkg::*;
(
    input  wire logic                  clk_i,
    input  wire logic                  run_i,
    input  wire logic [NCH*DATA_W-1:0] data_i,
    input  wire logic [NCH*CTRL_W-1:0] ctrl_i,
    input  wire logic                  full_par_i,
    input  wire logic [NCH-1:0]        bad_par_i,
    input  wire logic                  sc_i,
    output logic      [NCH*DATA_W-1:0] tx_char_bits_o,
    output logic      [NCH*CTRL_W-1:0] tx_ctrl_bits_o,
    output logic      [NCH-1:0]        tx_odd_parity_bit_o,
    output logic                       special_char_select_o,
    output logic                       link_clk_o,
    output logic      [NCH-2:0]        link_bcd_clk_o
);
    // ========================================================
    // input clock, frozen while stalled to provoke a skew fault
    initial begin
        link_clk_o = 1'b0;
        #3;
        forever begin
            #(CHAR_PERIOD_NS / 2);
            if (run_i) begin
                link_clk_o = ~link_clk_o;
            end
        end
    end
    assign link_bcd_clk_o = {(NCH-1){link_clk_o}};
    // ========================================================
    // character pins, odd parity unless told to break it
    always_ff @(posedge clk_i) begin
        tx_char_bits_o        <= data_i;
        tx_ctrl_bits_o        <= ctrl_i;
        special_char_select_o <= sc_i;
        for (int n = 0; n < NCH; n++) begin
            tx_odd_parity_bit_o[n] <= ~(^data_i[n*DATA_W +: DATA_W])
                ^ (full_par_i & (^ctrl_i[n*CTRL_W +: CTRL_W])) ^ bad_par_i[n];
        end
    end
endmodule

// ### phase_align_fifo.sv
// one channel's phase-align buffer with sticky skew error
`timescale 1ns/1ns
module phase_align_fifo
    import quad_tx_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               init_i,
    input  wire logic               wr_i,
    input  wire logic [ENTRY_W-1:0] wr_data_i,
    input  wire logic               rd_i,
    output logic      [ENTRY_W-1:0] rd_data_o,
    output logic                    err_o
);

    logic [ENTRY_W-1:0] mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0] wr_ptr_reg;
    logic [FIFO_AW-1:0] rd_ptr_reg;
    logic [2:0]         count_reg;
    logic               over;
    logic               under;

    assign over      = wr_i && !rd_i && count_reg == FIFO_FULL;
    assign under     = rd_i && count_reg == 3'h0;
    assign rd_data_o = mem[rd_ptr_reg];

    always_ff @(posedge clk_i) begin
        if (wr_i) begin
            mem[wr_ptr_reg] <= wr_data_i;
        end
    end

    // init centres the fill so drift of half a character either way fits
    always_ff @(posedge clk_i) begin
        if (init_i) begin
            wr_ptr_reg <= FIFO_AW'(FIFO_CENTER);
            rd_ptr_reg <= '0;
            count_reg  <= FIFO_CENTER;
        end else begin
            if (wr_i) begin
                wr_ptr_reg <= wr_ptr_reg + 2'h1;
            end
            if (rd_i) begin
                rd_ptr_reg <= rd_ptr_reg + 2'h1;
            end
            if (!over && !under) begin
                count_reg <= count_reg + 3'(wr_i) - 3'(rd_i);
            end
        end
    end

    // held until the buffer is initialised again
    always_ff @(posedge clk_i) begin
        if (init_i) begin
            err_o <= 1'b0;
        end else if (over || under) begin
            err_o <= 1'b1;
        end
    end

endmodule

// ### quad_tx_input_phase_align_parity.sv
// transmit input registers, phase-align buffers and odd-parity check
//
// The AHB-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
// How it works
// R1 - capture eight data, two control bits
// R2 - bypass: control bits form char bits 9:8
// R3 - encoder on: control plus data pick char
// R4 - lower mode not high: capture special select
// R5 - common clock: select applies all channels
// R6 - per-channel clocks: select taken on chan A
// R7 - reference clock, selects low: bypass buffers
// R8 - other clocking or dual edge: use buffers
// R9 - two low reset samples initialise buffers
// R10 - tolerate half-character drift either way
// R11 - skew overflow: error held until reset
// R12 - skew error: send C0.7 continuously
// R13 - atomic mode word sync re-centres buffer
// R14 - host repeats word sync after re-centre
// R15 - capture parity bit, check in parity modes mid and high
// R16 - mid with encoder: data plus parity only
// R17 - high or bypass-mid: data, control, parity
// R18 - parity mode low: no checking
// R19 - xor of checked bits must be one
// R20 - encoder on: substitute C0.7 on error
// R21 - bypass: substitute positive C0.7 pattern
// R22 - parity error on channel error flag
// R23 - positive C0.7 is 1001111000
// R24 - parity error flag with substituted char
module quad_tx_input_phase_align_parity
    import quad_tx_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 reset_i,
    input  wire logic                 hsel_i,
    input  wire logic [31:0]          haddr_i,
    input  wire logic [1:0]           htrans_i,
    input  wire logic                 hwrite_i,
    input  wire logic [2:0]           hsize_i,
    input  wire logic [31:0]          hwdata_i,
    input  wire logic                 hready_i,
    output logic      [31:0]          hrdata_o,
    output logic                      hreadyout_o,
    output logic                      hresp_o,
    input  wire logic [NCH*DATA_W-1:0] tx_char_bits_i,
    input  wire logic [NCH*CTRL_W-1:0] tx_ctrl_bits_i,
    input  wire logic [NCH-1:0]       tx_odd_parity_bit_i,
    input  wire logic                 special_char_select_i,
    input  wire logic                 chan_a_input_clock_i,
    input  wire logic [NCH-2:0]       chan_bcd_input_clock_i,
    input  wire logic                 tx_align_reset_n_i,
    input  wire logic [NCH-1:0]       word_sync_sent_i,
    output logic      [NCH*CHAR_W-1:0] raw_char_bits_o,
    output logic      [NCH-1:0]       subst_c07_o,
    output logic                      sc_sel_o,
    output logic                      char_valid_o,
    output logic      [NCH-1:0]       tx_error_flag_o
);

    // ========================================================
    // configuration register and decoded selects
    logic [31:0]  cfg_reg;
    logic [1:0]   umode;
    logic [1:0]   lmode;
    logic [1:0]   cksel;
    logic         dual;
    logic [1:0]   pmode;
    logic         enc_on;
    logic         buf_en;

    assign umode  = cfg_reg[CFG_UMODE +: 2];
    assign lmode  = cfg_reg[CFG_LMODE +: 2];
    assign cksel  = cfg_reg[CFG_CKSEL +: 2];
    assign dual   = cfg_reg[CFG_DUAL];
    assign pmode  = cfg_reg[CFG_PAR +: 2];
    assign enc_on = umode != LVL_LOW; // R3
    assign buf_en = cksel != LVL_LOW || dual; // R7 R8

    // ========================================================
    // pin synchronisers
    logic [PIN_W-1:0] pin_meta_reg;
    logic [PIN_W-1:0] pin_sync_reg;
    logic [NCH-1:0]   clk_meta_reg;
    logic [NCH-1:0]   clk_sync_reg;
    logic [NCH-1:0]   clk_prev_reg;
    logic             rst_meta_reg;
    logic             rst_sync_reg;

    always_ff @(posedge clk_i) begin
        pin_meta_reg <= {special_char_select_i, tx_odd_parity_bit_i,
                         tx_ctrl_bits_i, tx_char_bits_i};
        pin_sync_reg <= pin_meta_reg;
    end

    always_ff @(posedge clk_i) begin
        clk_meta_reg <= {chan_bcd_input_clock_i, chan_a_input_clock_i};
        clk_sync_reg <= clk_meta_reg;
        clk_prev_reg <= clk_sync_reg;
    end

    // asynchronous pin, resampled before the state machines see it
    always_ff @(posedge clk_i) begin
        rst_meta_reg <= tx_align_reset_n_i;
        rst_sync_reg <= rst_meta_reg;
    end

    // ========================================================
    // pin fields
    logic [NCH*DATA_W-1:0] pin_data;
    logic [NCH*CTRL_W-1:0] pin_ctrl;
    logic [NCH-1:0]        pin_par;
    logic                  pin_sc;
    logic                  sc_now;
    logic [NCH-1:0]        clk_rise;

    assign pin_data = pin_sync_reg[0 +: NCH*DATA_W];
    assign pin_ctrl = pin_sync_reg[NCH*DATA_W +: NCH*CTRL_W];
    assign pin_par  = pin_sync_reg[NCH*(DATA_W+CTRL_W) +: NCH]; // R15
    assign pin_sc   = pin_sync_reg[PIN_W-1];
    // select ignored when the lower select is high or encoder is off
    assign sc_now   = pin_sc && lmode != LVL_HIGH && enc_on; // R4
    assign clk_rise = clk_sync_reg & ~clk_prev_reg;

    // ========================================================
    // internal character clock
    logic [4:0] char_cnt_reg;
    logic       char_tick;

    assign char_tick = char_cnt_reg == CHAR_LAST;

    always_ff @(posedge clk_i) begin
        if (reset_i || char_tick) begin
            char_cnt_reg <= '0;
        end else begin
            char_cnt_reg <= char_cnt_reg + 5'h1;
        end
    end

    // ========================================================
    // special select held from the channel A clock
    logic sc_a_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sc_a_reg <= 1'b0;
        end else if (clk_rise[0]) begin
            sc_a_reg <= sc_now; // R6
        end
    end

    // ========================================================
    // buffer initialisation from the align reset pin
    logic [1:0] rst_low_reg;
    logic       align_init;

    always_ff @(posedge clk_i) begin
        if (reset_i || rst_sync_reg) begin
            rst_low_reg <= '0;
        end else if (rst_low_reg != RST_SAMPLES) begin
            rst_low_reg <= rst_low_reg + 2'h1;
        end
    end

    // held while low, so the phase is set by the release
    assign align_init = rst_low_reg == RST_SAMPLES; // R9

    // ========================================================
    // per-channel input capture and buffers
    logic [ENTRY_W-1:0] src   [NCH];
    logic [NCH-1:0]     aerr;
    logic [NCH-1:0]     perr;

    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        logic [ENTRY_W-1:0] entry;
        logic [ENTRY_W-1:0] rd_data;
        logic               cap;
        logic               init;
        logic               recenter;
        logic               sc_w;
        logic               x_data;
        logic               x_ctrl;
        logic               x_par;
        logic               fifo_err;

        // per-channel clocks take the select from channel A
        assign sc_w = cksel == LVL_HIGH ? sc_a_reg : sc_now; // R5 R6

        assign entry = {sc_w, pin_par[ch],
                        pin_ctrl[ch*CTRL_W +: CTRL_W],
                        pin_data[ch*DATA_W +: DATA_W]}; // R1 R15

        // capture strobe from the selected input clock
        always_comb begin
            unique case (cksel)
                LVL_MID:  cap = clk_rise[0];
                LVL_HIGH: cap = clk_rise[ch];
                default:  cap = char_tick;
            endcase
        end

        assign recenter = umode == LVL_MID && fifo_err &&
                          word_sync_sent_i[ch]; // R13 R14
        assign init = reset_i || align_init || !buf_en || recenter;

        phase_align_fifo u_fifo (
            .clk_i     (clk_i),
            .init_i    (init),
            .wr_i      (cap && buf_en),
            .wr_data_i (entry),
            .rd_i      (char_tick && buf_en),
            .rd_data_o (rd_data),
            .err_o     (fifo_err)
        ); // R10 R11

        assign aerr[ch] = fifo_err; // R11
        // latency trade: buffer skipped on the reference clock
        assign src[ch] = buf_en ? rd_data : entry; // R7

        assign x_data = ^src[ch][0 +: DATA_W];
        assign x_ctrl = ^src[ch][DATA_W +: CTRL_W];
        assign x_par  = src[ch][PAR_POS];

        always_comb begin
            unique case (pmode)
                LVL_MID:  perr[ch] = enc_on ? !(x_data ^ x_par)
                                   : !(x_data ^ x_ctrl ^ x_par); // R16 R17 R19
                LVL_HIGH: perr[ch] = !(x_data ^ x_ctrl ^ x_par); // R17 R19
                default:  perr[ch] = 1'b0; // R18
            endcase
        end
    end

    // ========================================================
    // character output stage
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            raw_char_bits_o <= '0;
            subst_c07_o     <= '0;
            sc_sel_o        <= 1'b0;
        end else if (char_tick) begin
            for (int ch = 0; ch < NCH; ch++) begin
                if (!enc_on && (perr[ch] || aerr[ch])) begin // R12
                    raw_char_bits_o[ch*CHAR_W +: CHAR_W] <= C07_POS; // R21 R23
                end else begin
                    raw_char_bits_o[ch*CHAR_W +: CHAR_W] <=
                        src[ch][0 +: CHAR_W]; // R2 R3
                end
                // encoder applies running disparity to the C0.7
                subst_c07_o[ch] <= enc_on && (perr[ch] || aerr[ch]); // R20 R12
            end
            // channel A's entry carries the select for all four
            sc_sel_o <= src[0][SC_POS]; // R5 R6
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            char_valid_o <= 1'b0;
        end else begin
            char_valid_o <= char_tick;
        end
    end

    // skew error is a level; parity error marks one character
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            tx_error_flag_o <= '0;
        end else begin
            tx_error_flag_o <= aerr | (perr & {NCH{char_tick}}); // R11 R22 R24
        end
    end

    // ========================================================
    // AHB-Lite slave, zero wait states
    logic       ap_valid_reg;
    logic       ap_write_reg;
    logic [7:0] ap_addr_reg;
    logic       ap_take;
    logic [7:0] ap_addr;
    logic       cfg_wr;
    logic [31:0] cfg_now;

    assign ap_take = hsel_i && htrans_i[1] && hready_i;
    assign ap_addr = {haddr_i[7:2], 2'h0};
    assign cfg_wr  = ap_valid_reg && ap_write_reg && ap_addr_reg == CFG_OFS;
    // forward a write in its data phase to a read just behind it
    assign cfg_now = cfg_wr ? (hwdata_i & CFG_MASK) : cfg_reg;

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ap_valid_reg <= 1'b0;
            ap_write_reg <= 1'b0;
            ap_addr_reg  <= '0;
        end else if (hready_i) begin
            ap_valid_reg <= ap_take;
            ap_write_reg <= hwrite_i;
            ap_addr_reg  <= ap_addr;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            cfg_reg <= CFG_RESET;
        end else if (cfg_wr) begin
            cfg_reg <= hwdata_i & CFG_MASK;
        end
    end

    // read data prepared at the address phase edge
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hrdata_o <= '0;
        end else if (ap_take && !hwrite_i) begin
            unique case (ap_addr)
                CFG_OFS:  hrdata_o <= cfg_now;
                STAT_OFS: hrdata_o <= {27'h0, buf_en, aerr};
                default:  hrdata_o <= '0;
            endcase
        end
    end

    // every access completes at once with OKAY
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

endmodule

// ### quad_tx_pkg.sv
// constants shared by the transmit input stage and its phase-align buffer
package quad_tx_pkg;

    // ========================================================
    // three-level selects, coded in two bits
    localparam logic [1:0] LVL_LOW  = 2'h0;
    localparam logic [1:0] LVL_MID  = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;

    // ========================================================
    // channel and character layout
    localparam int NCH     = 4;
    localparam int DATA_W  = 8;
    localparam int CTRL_W  = 2;
    localparam int CHAR_W  = 10;
    // entry: {sc, parity, ctrl[1:0], data[7:0]}
    localparam int ENTRY_W = 12;
    localparam int PAR_POS = 10;
    localparam int SC_POS  = 11;
    localparam int PIN_W   = NCH * (DATA_W + CTRL_W + 1) + 1;

    // positive-disparity C0.7, 1001111000
    localparam logic [CHAR_W-1:0] C07_POS = 10'h278;

    // ========================================================
    // phase-align buffer geometry
    localparam int         FIFO_DEPTH  = 4;
    localparam int         FIFO_AW     = 2;
    localparam logic [2:0] FIFO_FULL   = 3'h4;
    localparam logic [2:0] FIFO_CENTER = 3'h2;
    localparam logic [1:0] RST_SAMPLES = 2'h2;

    // ========================================================
    // timing
    localparam int CLK_PERIOD_NS  = 8;
    localparam int CHAR_PERIOD_NS = 160;
    localparam int CHAR_CYCLES    = CHAR_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [4:0] CHAR_LAST = 5'(CHAR_CYCLES - 1);

    // ========================================================
    // register map
    localparam logic [7:0]  CFG_OFS   = 8'h00;
    localparam logic [7:0]  STAT_OFS  = 8'h04;
    localparam int          CFG_UMODE = 0;
    localparam int          CFG_LMODE = 2;
    localparam int          CFG_CKSEL = 4;
    localparam int          CFG_DUAL  = 6;
    localparam int          CFG_PAR   = 8;
    localparam logic [31:0] CFG_MASK  = 32'h0000037f;
    localparam logic [31:0] CFG_RESET = 32'h00000000;
    localparam int          STAT_BUF  = 4;

endpackage

// ### quad_tx_props.sv
// assertion checker for the transmit input stage
`timescale 1ns/1ns
module quad_tx_props
    import quad_tx_pkg::*;
(
    input wire logic                  clk_i,
    input wire logic                  reset_i,
    input wire logic                  hsel_i,
    input wire logic [31:0]           haddr_i,
    input wire logic [1:0]            htrans_i,
    input wire logic                  hwrite_i,
    input wire logic                  hready_i,
    input wire logic [31:0]           hrdata_o,
    input wire logic [NCH*CHAR_W-1:0] raw_char_bits_o,
    input wire logic [NCH-1:0]        subst_c07_o,
    input wire logic                  sc_sel_o,
    input wire logic                  char_valid_o,
    input wire logic [NCH-1:0]        tx_error_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire       rd_a = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    wire [5:0] idx  = haddr_i[7:2];
    // ========================================================
    // character strobe and hold
    property p_gap; char_valid_o |=> !char_valid_o [*8]; endproperty
    a_gap: assert property (p_gap) else $error("strobe too close");
    property p_hold; !char_valid_o |-> $stable(raw_char_bits_o); endproperty
    a_hold: assert property (p_hold) else $error("char moved");
    property p_side; !char_valid_o |-> $stable({subst_c07_o, sc_sel_o});
    endproperty
    a_side: assert property (p_side) else $error("select moved");
    // ========================================================
    // error handling, channel 0 stands for all
    property p_sub; char_valid_o && tx_error_flag_o[0] |->
        subst_c07_o[0] || raw_char_bits_o[9:0] == C07_POS; endproperty
    a_sub: assert property (p_sub) else $error("no substitute");
    // a cfg write may legally drop the buffers, so skip around it
    property p_lvl; $rose(tx_error_flag_o[0]) && !char_valid_o && !hsel_i
        && !$past(hsel_i) |=> tx_error_flag_o[0] [*2]; endproperty
    a_lvl: assert property (p_lvl) else $error("skew flag dropped");
    // ========================================================
    // register reads
    property p_unmap; rd_a && idx > STAT_OFS[7:2] |=> hrdata_o == 32'h0;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped not zero");
    property p_cfgrd; rd_a && idx == CFG_OFS[7:2] |=>
        (hrdata_o & ~CFG_MASK) == 32'h0; endproperty
    a_cfgrd: assert property (p_cfgrd) else $error("cfg spare bits set");
    property p_strd; rd_a && idx == STAT_OFS[7:2] |=> hrdata_o[31:5] == 27'h0;
    endproperty
    a_strd: assert property (p_strd) else $error("status spare bits set");
    c_par: cover property (char_valid_o && tx_error_flag_o[0]);
    c_skew: cover property ($rose(tx_error_flag_o[0]) && !char_valid_o);
    c_sc: cover property (char_valid_o && sc_sel_o);
endmodule

bind quad_tx_input_phase_align_parity quad_tx_props quad_tx_props_inst (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hrdata_o(hrdata_o), .raw_char_bits_o(raw_char_bits_o),
    .subst_c07_o(subst_c07_o), .sc_sel_o(sc_sel_o),
    .char_valid_o(char_valid_o), .tx_error_flag_o(tx_error_flag_o));

// ### test_quad_tx_input_phase_align_parity.sv
// self-checking bench for the transmit input stage
`timescale 1ns/1ns
module test_quad_tx_input_phase_align_parity
    import quad_tx_pkg::*;
;
    logic           clk_i = 1'b0;
    logic           reset_i = 1'b1;
    logic           hsel = 1'b0;
    logic           hwrite = 1'b0;
    logic [1:0]     htrans = 2'h0;
    logic [31:0]    haddr = 32'h0;
    logic [31:0]    hwdata = 32'h0;
    logic [31:0]    hrdata, rd_val;
    logic           hready, hresp, lclk, sc_w, sc_out, cvalid;
    logic           run = 1'b1;
    logic           full_par = 1'b1;
    logic           sc = 1'b0;
    logic           align_n = 1'b1;
    logic [NCH-1:0] bad_par = 4'h0;
    logic [NCH-1:0] wsync = 4'h0;
    logic [NCH-1:0] par_w, subst, err;
    logic [NCH-2:0] bcd;
    logic [31:0]    data = 32'h3cc35aa5;
    logic [7:0]     ctrl = 8'h9c;
    logic [31:0]    char_w;
    logic [7:0]     ctrl_w;
    logic [39:0]    raw;
    int             fail_count = 0;
    int             num_checks = 0;

    always #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

    host_char_source host_char_source_inst (
        .clk_i(clk_i), .run_i(run), .data_i(data), .ctrl_i(ctrl),
        .full_par_i(full_par), .bad_par_i(bad_par), .sc_i(sc),
        .tx_char_bits_o(char_w), .tx_ctrl_bits_o(ctrl_w),
        .tx_odd_parity_bit_o(par_w), .special_char_select_o(sc_w),
        .link_clk_o(lclk), .link_bcd_clk_o(bcd));
    quad_tx_input_phase_align_parity quad_tx_input_phase_align_parity_inst (
        .clk_i(clk_i), .reset_i(reset_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
        .hreadyout_o(hready), .hresp_o(hresp), .tx_char_bits_i(char_w),
        .tx_ctrl_bits_i(ctrl_w), .tx_odd_parity_bit_i(par_w),
        .special_char_select_i(sc_w), .chan_a_input_clock_i(lclk),
        .chan_bcd_input_clock_i(bcd), .tx_align_reset_n_i(align_n),
        .word_sync_sent_i(wsync), .raw_char_bits_o(raw),
        .subst_c07_o(subst), .sc_sel_o(sc_out), .char_valid_o(cvalid),
        .tx_error_flag_o(err));

    // ========================================================
    // shared helpers
    task automatic check(input string nm, input logic [39:0] exp, got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd_val = hrdata;
        check("hresp", 40'h0, 40'(hresp));
    endtask

    function automatic logic [31:0] cfg(input logic [1:0] um, lm, ck, pm,
                                        input logic du);
        return {22'h0, pm, 1'b0, du, ck, lm, um};
    endfunction

    function automatic logic [39:0] pass_chars();
        for (int n = 0; n < NCH; n++) begin
            pass_chars[n*CHAR_W +: CHAR_W] = {ctrl[2*n +: 2], data[8*n +: 8]};
        end
    endfunction

    // bounded: a missing strobe counts as a mismatch
    task automatic wait_chars(input int n);
        int k;
        repeat (n) begin
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (cvalid !== 1'b1 && k < 40);
            check("strobe", 40'h1, 40'(cvalid));
        end
    endtask

    task automatic pulse_align();
        align_n <= 1'b0;
        repeat (8) @(posedge clk_i);
        align_n <= 1'b1;
    endtask

    // ========================================================
    // scenarios
    task automatic t_regs();
        bus(1'b0, CFG_OFS, 32'h0);
        check("cfg reset", 40'(CFG_RESET), 40'(rd_val));
        bus(1'b0, STAT_OFS, 32'h0);
        check("status reset", 40'h0, 40'(rd_val));
        bus(1'b1, CFG_OFS, 32'hffffffff);
        bus(1'b0, CFG_OFS, 32'h0);
        check("cfg mask", 40'(CFG_MASK), 40'(rd_val));
        bus(1'b0, 8'h08, 32'h0);
        check("unmapped", 40'h0, 40'(rd_val));
        bus(1'b1, CFG_OFS, 32'h0);
    endtask

    task automatic t_bypass();
        bad_par <= 4'h2;
        wait_chars(3);
        check("bypass chars", pass_chars(), raw);
        check("no parity", 40'h0, 40'(err));
        bus(1'b1, CFG_OFS, cfg(LVL_LOW, LVL_LOW, LVL_LOW, LVL_MID, 1'b0));
        wait_chars(3);
        check("bypass c07", (pass_chars() & 40'hfffff003ff) |
              (40'(C07_POS) << 10), raw);
        check("parity flag", 40'h2, 40'(err));
        @(posedge clk_i);
        check("flag pulse", 40'h0, 40'(err));
        bad_par <= 4'h0;
    endtask

    task automatic t_encoder();
        full_par <= 1'b0;
        bus(1'b1, CFG_OFS, cfg(LVL_MID, LVL_LOW, LVL_LOW, LVL_MID, 1'b0));
        wait_chars(3);
        check("enc chars", pass_chars(), raw);
        check("data parity", 40'h0, 40'(err));
        bus(1'b1, CFG_OFS, cfg(LVL_MID, LVL_LOW, LVL_LOW, LVL_HIGH, 1'b0));
        wait_chars(3);
        check("full parity", 40'hc, 40'(err));
        check("enc subst", 40'hc, 40'(subst));
        full_par <= 1'b1;
        wait_chars(3);
        check("full parity ok", 40'h0, 40'(err));
    endtask

    task automatic t_sc();
        sc <= 1'b1;
        wait_chars(3);
        check("sc on", 40'h1, 40'(sc_out));
        sc <= 1'b0;
        wait_chars(3);
        check("sc off", 40'h0, 40'(sc_out));
        sc <= 1'b1;
        bus(1'b1, CFG_OFS, cfg(LVL_MID, LVL_HIGH, LVL_LOW, LVL_LOW, 1'b0));
        wait_chars(3);
        check("sc unused", 40'h0, 40'(sc_out));
    endtask

    task automatic t_buf();
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, CFG_OFS, cfg(2'h0, 2'h0, (i < 3) ? 2'(i) : 2'h0,
                                   2'h0, i == 3));
            bus(1'b0, STAT_OFS, 32'h0);
            check("buffers on", 40'(i != 0), 40'(rd_val[STAT_BUF]));
        end
    endtask

    task automatic t_align();
        bus(1'b1, CFG_OFS, cfg(LVL_MID, LVL_LOW, LVL_MID, LVL_LOW, 1'b0));
        pulse_align();
        wait_chars(8);
        check("aligned", 40'h0, 40'(err));
        check("buffered chars", pass_chars(), raw);
        run <= 1'b0;
        wait_chars(10);
        check("skew flag", 40'hf, 40'(err));
        check("skew subst", 40'hf, 40'(subst));
        run <= 1'b1;
        wait_chars(6);
        check("skew sticky", 40'hf, 40'(err));
        wsync <= 4'h1;
        @(posedge clk_i);
        wsync <= 4'h0;
        wait_chars(4);
        check("recentred", 40'he, 40'(err));
        pulse_align();
        wait_chars(8);
        check("realigned", 40'h0, 40'(err));
        bus(1'b1, CFG_OFS, cfg(LVL_MID, LVL_LOW, LVL_HIGH, LVL_LOW, 1'b0));
        pulse_align();
        wait_chars(8);
        check("sc from chan a", 40'h1, 40'(sc_out));
    endtask

    task automatic report_and_stop();
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #200000;
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        t_regs();
        t_bypass();
        t_encoder();
        t_sc();
        t_buf();
        t_align();
        report_and_stop();
    end
endmodule
